// file: flash_ctrl_consts.svh
// Constants for the flash key, write and erase controller
`ifndef FLASH_CTRL_CONSTS_SVH
`define FLASH_CTRL_CONSTS_SVH
`define KEY_FIRST 8'ha5
`define KEY_SECOND 8'hf1
`define PSC_WE_BIT 0
`define PSC_EE_BIT 1
`define PAGE_ADDR_BITS 9
`define ERASED_BYTE 8'hff
`define ADDR_W 16
`define LOCK_LOCKED 2'h0
`define LOCK_FIRST 2'h1
`define LOCK_OPEN 2'h2
`define LOCK_DEAD 2'h3
`endif

// file: flash_ctrl_pkg.sv
// Types shared by both ends of the flash controller link
package flash_ctrl_pkg;
    typedef enum logic [1:0] {
        ST_LOCKED,
        ST_FIRST,
        ST_OPEN,
        ST_DEAD
    } lock_e;
    typedef logic [7:0] byte_t;
endpackage

// file: flash_ctrl_if.sv
// Link between the CPU-side end and the flash controller
`timescale 1ns/1ps
`default_nettype none
interface flash_ctrl_if;
    logic key_wr;
    logic ctl_wr;
    logic xwr;
    logic xrd;
    logic [15:0] addr;
    logic [7:0] wdata;
    logic [1:0] key_state;
    logic [1:0] ctl_state;
    logic stall;
    logic external_data_ram_wr;
    logic external_data_ram_rd;
    modport ctrl (input key_wr, ctl_wr, xwr, xrd, addr, wdata,
        output key_state, ctl_state, stall, external_data_ram_wr, external_data_ram_rd);
    modport cpu (output key_wr, ctl_wr, xwr, xrd, addr, wdata,
        input key_state, ctl_state, stall, external_data_ram_wr, external_data_ram_rd);
endinterface
`default_nettype wire

// file: flash_key_write_erase_ctrl.sv
// Flash key lock, write and page erase controller (device end)
// Contract
// - Keys A5 then F1 permit one operation
// - Gap between key writes does not matter
// - Wrong or misordered key locks until reset
// - Operation before unlock locks until reset
// - Lock re-arms after every completed operation
// - Write enable routes external writes to flash
// - Write enable clears only by software zero
// - Programming only clears bits: AND
// - Erase sets whole 512-byte page to FF
// - Erase plus write enable erases page
// - Write enable alone programs one byte
// - Software repeats whole sequence per byte
// - Interrupts held pending during operation
// - External reads always go to data RAM
// - Software disables interrupts around write enable
// - Software clears write enable when done
// - Reset-source writes by direct assignment only
// - Key read shows lock state in bits 1-0
// - Erase ignores the written data byte
// - Code stalls during operation, hardware timed
`timescale 1ns/1ps
`default_nettype none
`include "flash_ctrl_consts.svh"
module flash_key_write_erase_ctrl #(
    parameter int ADDR_W = `ADDR_W
) (
    input wire logic clk,
    input wire logic rst_n,
    flash_ctrl_if.ctrl bus,
    input wire logic irq_in,
    output logic irq_hold,
    output logic fl_prog,
    output logic fl_erase,
    output logic [ADDR_W-1:0] fl_addr,
    output logic [7:0] fl_wdata,
    input wire logic [7:0] fl_rdata,
    input wire logic fl_done
);
    import flash_ctrl_pkg::*;

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    lock_e lock_q;
    logic we_q;
    logic ee_q;
    logic busy_q;
    logic erase_op_q;
    logic stall_q;
    logic external_data_ram_wr_q;
    logic external_data_ram_rd_q;
    logic pend_q;
    logic hold_q;

    wire logic flash_wr = bus.xwr && we_q;

    // ------------------------------------------------------------
    // Write decode
    // ------------------------------------------------------------
    // A flash-bound write while idle either launches an operation or breaks the lock
    logic launch;
    logic misuse;
    assign launch = flash_wr && !busy_q && lock_q == ST_OPEN;
    assign misuse = flash_wr && !busy_q && lock_q != ST_OPEN;

    // Base address of the page that holds a byte; erase always works on whole pages
    function automatic logic [ADDR_W-1:0] page_base(input logic [ADDR_W-1:0] a);
        page_base = {a[ADDR_W-1:`PAGE_ADDR_BITS], {`PAGE_ADDR_BITS{1'b0}}};
    endfunction

    function automatic logic [1:0] lock_code(input lock_e s);
        unique case (s)
            ST_LOCKED: lock_code = `LOCK_LOCKED;
            ST_FIRST: lock_code = `LOCK_FIRST;
            ST_OPEN: lock_code = `LOCK_OPEN;
            ST_DEAD: lock_code = `LOCK_DEAD;
        endcase
    endfunction

    // ------------------------------------------------------------
    // Lock and key sequencer
    // ------------------------------------------------------------
    // Key writes advance the lock; only order and value count, never spacing
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            lock_q <= ST_LOCKED;
        end else if (lock_q == ST_DEAD) begin
            lock_q <= ST_DEAD;
        end else if (busy_q && fl_done) begin
            lock_q <= ST_LOCKED;
        end else if (misuse) begin
            lock_q <= ST_DEAD;
        end else if (bus.key_wr) begin
            unique case (lock_q)
                ST_LOCKED: lock_q <= (bus.wdata == `KEY_FIRST) ? ST_FIRST : ST_DEAD;
                ST_FIRST: lock_q <= (bus.wdata == `KEY_SECOND) ? ST_OPEN : ST_DEAD;
                ST_OPEN: lock_q <= ST_DEAD;
                ST_DEAD: lock_q <= ST_DEAD;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Program-store control bits
    // ------------------------------------------------------------
    // Both bits change only on a software control write
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            we_q <= 1'b0;
            ee_q <= 1'b0;
        end else if (bus.ctl_wr) begin
            we_q <= bus.wdata[`PSC_WE_BIT];
            ee_q <= bus.wdata[`PSC_EE_BIT];
        end
    end

    // ------------------------------------------------------------
    // Flash operation launch and stall
    // ------------------------------------------------------------
    // A write while open starts one operation; stall holds until done
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            busy_q <= 1'b0;
            erase_op_q <= 1'b0;
            stall_q <= 1'b0;
            fl_prog <= 1'b0;
            fl_erase <= 1'b0;
            fl_addr <= '0;
            fl_wdata <= 8'h00;
        end else if (busy_q) begin
            fl_prog <= 1'b0;
            fl_erase <= 1'b0;
            if (fl_done) begin
                busy_q <= 1'b0;
                stall_q <= 1'b0;
            end
        end else if (launch) begin
            busy_q <= 1'b1;
            stall_q <= 1'b1;
            erase_op_q <= ee_q;
            fl_erase <= ee_q;
            fl_prog <= !ee_q;
            if (ee_q) begin
                // Page base address; data byte is ignored
                fl_addr <= page_base(bus.addr[ADDR_W-1:0]);
                fl_wdata <= `ERASED_BYTE;
            end else begin
                fl_addr <= bus.addr[ADDR_W-1:0];
                fl_wdata <= fl_rdata & bus.wdata;
            end
        end
    end

    // ------------------------------------------------------------
    // Data RAM steering
    // ------------------------------------------------------------
    // Writes go to data RAM only with write enable clear; reads always do
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            external_data_ram_wr_q <= 1'b0;
            external_data_ram_rd_q <= 1'b0;
        end else begin
            external_data_ram_wr_q <= bus.xwr && !we_q;
            external_data_ram_rd_q <= bus.xrd;
        end
    end

    // ------------------------------------------------------------
    // Interrupt hold
    // ------------------------------------------------------------
    // Requests during an operation are latched in pend_q, which clears after it and drives no output
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pend_q <= 1'b0;
            hold_q <= 1'b0;
        end else begin
            // Rises with the launch so the hold covers the very first busy cycle
            hold_q <= launch || (busy_q && !fl_done);
            if (irq_in && busy_q) begin
                pend_q <= 1'b1;
            end else if (!busy_q) begin
                pend_q <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    // Every link output is a plain copy of a register
    assign irq_hold = hold_q;
    assign bus.stall = stall_q;
    assign bus.key_state = lock_code(lock_q);
    assign bus.ctl_state = {ee_q, we_q};
    assign bus.external_data_ram_wr = external_data_ram_wr_q;
    assign bus.external_data_ram_rd = external_data_ram_rd_q;

    logic unused_ok;
    assign unused_ok = pend_q | erase_op_q;
endmodule // flash_key_write_erase_ctrl
`default_nettype wire

// file: flash_cpu_end.sv
// CPU-side end: runs a key, enable, write, disable sequence per request
`timescale 1ns/1ps
`default_nettype none
`include "flash_ctrl_consts.svh"
module flash_cpu_end (
    input wire logic clk,
    input wire logic rst_n,
    flash_ctrl_if.cpu bus,
    input wire logic req,
    input wire logic req_erase,
    input wire logic [15:0] req_addr,
    input wire logic [7:0] req_data,
    output logic ack,
    output logic irq_mask
);
    import flash_ctrl_pkg::*;

    typedef enum logic [2:0] {
        C_IDLE, C_KEY1, C_KEY2, C_EN, C_WR, C_WAIT, C_DIS
    } cpu_e;
    cpu_e st_q;
    logic key_wr_q, ctl_wr_q, xwr_q, ack_q, mask_q;
    logic [15:0] addr_q;
    logic [7:0] data_q;
    logic erase_q;

    // ------------------------------------------------------------
    // Sequence: mask irq, keys, enables, one write, clear enables
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= C_IDLE;
            key_wr_q <= 1'b0;
            ctl_wr_q <= 1'b0;
            xwr_q <= 1'b0;
            ack_q <= 1'b0;
            mask_q <= 1'b0;
            addr_q <= 16'h0000;
            data_q <= 8'h00;
            erase_q <= 1'b0;
        end else begin
            key_wr_q <= 1'b0;
            ctl_wr_q <= 1'b0;
            xwr_q <= 1'b0;
            ack_q <= 1'b0;
            unique case (st_q)
                C_IDLE: if (req) begin
                    mask_q <= 1'b1;
                    erase_q <= req_erase;
                    addr_q <= req_addr;
                    st_q <= C_KEY1;
                end
                C_KEY1: begin
                    key_wr_q <= 1'b1;
                    data_q <= `KEY_FIRST;
                    st_q <= C_KEY2;
                end
                C_KEY2: begin
                    key_wr_q <= 1'b1;
                    data_q <= `KEY_SECOND;
                    st_q <= C_EN;
                end
                C_EN: begin
                    ctl_wr_q <= 1'b1;
                    data_q <= {6'h00, erase_q, 1'b1};
                    st_q <= C_WR;
                end
                C_WR: begin
                    xwr_q <= 1'b1;
                    data_q <= req_data;
                    st_q <= C_WAIT;
                end
                C_WAIT: if (!bus.stall && !xwr_q) begin
                    ctl_wr_q <= 1'b1;
                    data_q <= 8'h00;
                    st_q <= C_DIS;
                end
                C_DIS: begin
                    mask_q <= 1'b0;
                    ack_q <= 1'b1;
                    st_q <= C_IDLE;
                end
                default: st_q <= C_IDLE;
            endcase
        end
    end

    assign bus.key_wr = key_wr_q;
    assign bus.ctl_wr = ctl_wr_q;
    assign bus.xwr = xwr_q;
    assign bus.xrd = 1'b0;
    assign bus.addr = addr_q;
    assign bus.wdata = data_q;
    assign ack = ack_q;
    assign irq_mask = mask_q;
endmodule // flash_cpu_end
`default_nettype wire

// file: flash_link_properties.sv
// Concurrent checks on the link between the CPU end and the controller
`timescale 1ns/1ps
`default_nettype none
module flash_link_properties (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic key_wr,
    input wire logic ctl_wr,
    input wire logic xwr,
    input wire logic [7:0] wdata,
    input wire logic [1:0] key_state,
    input wire logic [1:0] ctl_state,
    input wire logic stall,
    input wire logic external_data_ram_wr
);
    // ----------
    // Assertions
    // ----------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    AST_KEY_FIRST: assert property (key_wr && key_state == 2'h0 && wdata == 8'ha5 |=> key_state == 2'h1)
        else $error("first key not taken");
    AST_KEY_OPEN: assert property (key_wr && key_state == 2'h1 && wdata == 8'hf1 |=> key_state == 2'h2)
        else $error("second key did not unlock");
    AST_STALL_ON: assert property (xwr && key_state == 2'h2 && ctl_state[0] |=> stall)
        else $error("no stall after flash write");
    AST_RELOCK: assert property ($fell(stall) |-> key_state == 2'h0)
        else $error("lock not re-armed at end of stall");
    AST_WE_KEEP: assert property (!ctl_wr |=> ctl_state == $past(ctl_state))
        else $error("control bits changed without a write");
    AST_CTL_LOAD: assert property (ctl_wr |=> ctl_state == $past(wdata[1:0]))
        else $error("control write not taken");
    AST_QUIET_STALL: assert property (stall |-> !key_wr && !ctl_wr && !xwr)
        else $error("strobe issued during stall");
    AST_NO_RAM_WR: assert property (xwr && ctl_state[0] |=> !external_data_ram_wr)
        else $error("flash write reached data RAM");
    AST_NEVER_DEAD: assert property (key_state != 2'h3)
        else $error("well-formed sequence locked the flash");
    C_ERASE: cover property (stall && ctl_state == 2'h3);
    C_PROG: cover property (stall && ctl_state == 2'h1);
    C_DONE: cover property ($fell(stall));
endmodule // flash_link_properties
`default_nettype wire

// file: flash_key_write_erase_ctrl_bench.sv
// Self-checking bench for the flash key, write and erase controller
`timescale 1ns/1ps
`default_nettype none
`include "flash_ctrl_consts.svh"
module flash_key_write_erase_ctrl_bench;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic req = 1'b0;
    logic req_erase = 1'b0;
    logic [15:0] req_addr = 16'h0000;
    logic [7:0] req_data = 8'h00;
    logic irq_in = 1'b0;
    logic fl_done = 1'b0;
    logic ack, irq_mask, irq_hold, fl_prog, fl_erase;
    logic [15:0] fl_addr;
    logic [7:0] fl_wdata;
    logic [7:0] mem [0:1023];
    logic [7:0] exp [0:1023];
    int num_errors = 0;
    int total_checks = 0;
    int dcnt = 0;
    // ---------------------
    // Clock, ends, checker
    // ---------------------
    always #10 clk = ~clk;
    flash_ctrl_if link ();
    flash_ctrl_if link_b ();
    flash_cpu_end flash_cpu_end_inst (.clk(clk), .rst_n(rst_n), .bus(link.cpu), .req(req), .req_erase(req_erase),
        .req_addr(req_addr), .req_data(req_data), .ack(ack), .irq_mask(irq_mask));
    flash_key_write_erase_ctrl flash_key_write_erase_ctrl_inst (.clk(clk), .rst_n(rst_n), .bus(link.ctrl),
        .irq_in(irq_in), .irq_hold(irq_hold), .fl_prog(fl_prog), .fl_erase(fl_erase), .fl_addr(fl_addr),
        .fl_wdata(fl_wdata), .fl_rdata(mem[link.addr[9:0]]), .fl_done(fl_done));
    // Second controller faces the bench, which breaks the key rules on purpose
    flash_key_write_erase_ctrl flash_key_write_erase_ctrl_inst_b (.clk(clk), .rst_n(rst_n), .bus(link_b.ctrl),
        .irq_in(1'b0), .irq_hold(), .fl_prog(), .fl_erase(), .fl_addr(), .fl_wdata(), .fl_rdata(8'hff),
        .fl_done(1'b0));
    flash_link_properties flash_link_properties_inst (.clk(clk), .rst_n(rst_n), .key_wr(link.key_wr),
        .ctl_wr(link.ctl_wr), .xwr(link.xwr), .wdata(link.wdata), .key_state(link.key_state),
        .ctl_state(link.ctl_state), .stall(link.stall), .external_data_ram_wr(link.external_data_ram_wr));
    // Flash array model: takes program and erase, reports done a few cycles on
    always @(negedge clk) begin
        if (fl_prog)
            mem[fl_addr[9:0]] <= fl_wdata;
        if (fl_erase) begin
            chk("erase data", fl_wdata, `ERASED_BYTE);
            for (int k = 0; k < 512; k++)
                mem[{fl_addr[9], k[8:0]}] <= `ERASED_BYTE;
        end
        if (fl_prog || fl_erase) begin
            dcnt <= 2 + $urandom_range(4);
            fl_done <= 1'b0;
        end else if (dcnt > 0) begin
            dcnt <= dcnt - 1;
            fl_done <= (dcnt == 1);
        end else begin
            fl_done <= 1'b0;
        end
    end
    // -------------
    // Shared tasks
    // -------------
    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] want);
        total_checks++;
        if (seen !== want) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", what, want, seen);
        end
    endtask
    task automatic wrap_up();
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic reset();
        rst_n <= 1'b0;
        repeat (16) @(negedge clk);
        rst_n <= 1'b1;
    endtask
    // One full CPU sequence, then compare the touched page with the model
    task automatic op(input logic er, input logic [9:0] a, input logic [7:0] d);
        int n;
        logic seen;
        seen = 1'b0;
        @(negedge clk);
        req <= 1'b1;
        req_erase <= er;
        req_addr <= {6'h00, a};
        req_data <= d;
        @(negedge clk);
        req <= 1'b0;
        for (n = 0; n < 300 && ack !== 1'b1; n++) begin
            @(negedge clk);
            irq_in <= 1'($urandom_range(1));
            if (link.stall === 1'b1 && !seen) begin
                seen = 1'b1;
                chk("irq hold", irq_hold, 1);
                chk("enables", link.ctl_state, {er, 1'b1});
                chk("irq mask", irq_mask, 1);
            end
        end
        if (n == 300) begin
            num_errors++;
            wrap_up();
        end
        chk("stalled", seen, 1);
        chk("relocked", link.key_state, `LOCK_LOCKED);
        chk("we cleared", link.ctl_state, 2'h0);
        chk("irq released", irq_hold, 0);
        chk("mask released", irq_mask, 0);
        for (int k = 0; k < 512; k++)
            if (er || k[8:0] == a[8:0])
                exp[{a[9], k[8:0]}] = er ? `ERASED_BYTE : exp[a] & d;
        for (int k = 0; k < 512; k++)
            chk("flash byte", mem[{a[9], k[8:0]}], exp[{a[9], k[8:0]}]);
    endtask
    // Single strobe on the second link, outputs settled on return
    task automatic s2(input int kind, input logic [7:0] v);
        @(negedge clk);
        link_b.wdata <= v;
        link_b.key_wr <= (kind == 0);
        link_b.ctl_wr <= (kind == 1);
        link_b.xwr <= (kind == 2);
        link_b.xrd <= (kind == 3);
        @(negedge clk);
        {link_b.key_wr, link_b.ctl_wr, link_b.xwr, link_b.xrd} <= 4'h0;
    endtask
    // -------------
    // Main sequence
    // -------------
    initial begin
        void'($urandom(32'h0b8a6c35));
        {link_b.key_wr, link_b.ctl_wr, link_b.xwr, link_b.xrd} = 4'h0;
        link_b.addr = 16'h0000;
        link_b.wdata = 8'h00;
        for (int k = 0; k < 1024; k++) begin
            mem[k] = 8'($urandom);
            exp[k] = mem[k];
        end
        reset();
        op(1'b1, 10'h005, 8'h00);
        op(1'b0, 10'h005, 8'h3c);
        op(1'b0, 10'h005, 8'hf5);
        op(1'b0, 10'h1ff, 8'($urandom));
        op(1'b1, 10'h3ff, 8'h5a);
        repeat (6) op(1'($urandom_range(1)), 10'($urandom), 8'($urandom));
        s2(1, 8'h01);
        s2(3, 8'h00);
        chk("ram read", link_b.external_data_ram_rd, 1);
        chk("we held", link_b.ctl_state, 2'h1);
        s2(0, `KEY_SECOND);
        chk("misorder", link_b.key_state, `LOCK_DEAD);
        s2(0, `KEY_FIRST);
        s2(0, `KEY_SECOND);
        chk("stays dead", link_b.key_state, `LOCK_DEAD);
        reset();
        s2(2, 8'h00);
        chk("ram write", link_b.external_data_ram_wr, 1);
        s2(1, 8'h01);
        s2(2, 8'h00);
        chk("early op", {link_b.key_state, link_b.external_data_ram_wr}, {`LOCK_DEAD, 1'b0});
        reset();
        s2(0, `KEY_FIRST);
        repeat ($urandom_range(20)) @(negedge clk);
        s2(0, `KEY_SECOND);
        chk("slow keys", link_b.key_state, `LOCK_OPEN);
        s2(0, `KEY_FIRST);
        chk("key when open", link_b.key_state, `LOCK_DEAD);
        wrap_up();
    end
endmodule // flash_key_write_erase_ctrl_bench
`default_nettype wire
